/* File: hdl/tdchb_port.v */
// host bus port of an eight channel time-to-digital converter
`include "tdchb_defines.vh"
`default_nettype none
module tdchb_port (
    // clock and reset
    input wire ref_clk_i,
    input wire rst_n_i,
    // bus pins
    input wire chip_select_n_i,
    input wire read_strobe_n_i,
    input wire write_strobe_n_i,
    input wire output_drive_hold_n_i,
    input wire [`TDCHB_AW-1:0] addr_i,
    input wire [`TDCHB_DW-1:0] data_i,
    output reg [`TDCHB_DW-1:0] data_o,
    output reg data_oe_o,
    output reg fifo_one_empty_indicator_o,
    output reg fifo_two_empty_indicator_o,
    // reset and hit pins
    input wire master_reset_i,
    input wire partial_reset_i,
    input wire start_hit_i,
    input wire [`TDCHB_NSTOP-1:0] stop_hit_i,
    output reg start_hit_o,
    output reg [`TDCHB_NSTOP-1:0] stop_hit_o,
    output reg hit_accept_o,
    // measurement results into the interface fifos
    input wire [1:0] result_valid_i,
    output wire [1:0] result_ready_o,
    input wire [2*`TDCHB_DW-1:0] result_data_i,
    // configuration writes towards the core
    output reg cfg_we_o,
    output reg [`TDCHB_AW-1:0] cfg_addr_o,
    output reg [`TDCHB_DW-1:0] cfg_data_o,
    output reg narrow_mode_o
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    localparam SW = 6 + `TDCHB_AW + `TDCHB_DW + 1 + `TDCHB_NSTOP;
    // windows in clock cycles, rounded up, then cut to counter width
    localparam integer MRISE_N = (`TDCHB_MRST_RISE_NS * 1000
        + `TDCHB_CLK_PS - 1) / `TDCHB_CLK_PS;
    localparam integer MFALL_N = (`TDCHB_MRST_FALL_NS * 1000
        + `TDCHB_CLK_PS - 1) / `TDCHB_CLK_PS;
    localparam integer PRISE_N = (`TDCHB_PRST_RISE_NS * 1000
        + `TDCHB_CLK_PS - 1) / `TDCHB_CLK_PS;
    localparam integer PFALL_N = (`TDCHB_PRST_FALL_NS * 1000
        + `TDCHB_CLK_PS - 1) / `TDCHB_CLK_PS;
    localparam [`TDCHB_CW-1:0] MRISE_CYC = MRISE_N[`TDCHB_CW-1:0];
    localparam [`TDCHB_CW-1:0] MFALL_CYC = MFALL_N[`TDCHB_CW-1:0];
    localparam [`TDCHB_CW-1:0] PRISE_CYC = PRISE_N[`TDCHB_CW-1:0];
    localparam [`TDCHB_CW-1:0] PFALL_CYC = PFALL_N[`TDCHB_CW-1:0];

    wire [SW-1:0] pins = {master_reset_i, partial_reset_i,
        output_drive_hold_n_i, read_strobe_n_i, write_strobe_n_i,
        chip_select_n_i, addr_i, data_i, start_hit_i, stop_hit_i};
    reg [SW-1:0] s1_q;
    reg [SW-1:0] s2_q;
    reg [5:0] s3_q;

    // two flops, then a third stage of the control pins for edges;
    // reset to the idle pin levels so no false edge follows reset
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= {`TDCHB_PIN_IDLE, {(SW-6){1'b0}}};
            s2_q <= {`TDCHB_PIN_IDLE, {(SW-6){1'b0}}};
            s3_q <= `TDCHB_PIN_IDLE;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q[SW-1:SW-6];
        end
    end

    wire mrst = s2_q[SW-1];
    wire prst = s2_q[SW-2];
    wire hold_n = s2_q[SW-3];
    wire rd_act = !s2_q[SW-4] && !s2_q[SW-6];
    wire wr_act = !s2_q[SW-5] && !s2_q[SW-6];
    wire rd_act_old = !s3_q[2] && !s3_q[0];
    wire wr_act_old = !s3_q[1] && !s3_q[0];
    wire [`TDCHB_AW-1:0] addr = s2_q[SW-7:SW-6-`TDCHB_AW];
    wire [`TDCHB_DW-1:0] wdata = s2_q[`TDCHB_DW+`TDCHB_NSTOP:
        `TDCHB_NSTOP+1];
    wire start_s = s2_q[`TDCHB_NSTOP];
    wire [`TDCHB_NSTOP-1:0] stop_s = s2_q[`TDCHB_NSTOP-1:0];
    wire rd_begin = rd_act && !rd_act_old;
    wire rd_end = !rd_act && rd_act_old;
    wire wr_end = !wr_act && wr_act_old;
    wire mrst_rise = mrst && !s3_q[5];
    wire mrst_fall = !mrst && s3_q[5];
    wire prst_rise = prst && !s3_q[4];
    wire prst_fall = !prst && s3_q[4];

    // ****************************************
    // interface fifos
    // ****************************************
    wire [1:0] head_valid;
    wire [2*`TDCHB_DW-1:0] head_data;
    reg [1:0] pop;
    reg rd_phase_q;
    reg [`TDCHB_MSW_W-1:0] msw_q;
    wire sel_two = (addr == `TDCHB_ADDR_FIFO2);
    wire sel_fifo = sel_two || (addr == `TDCHB_ADDR_FIFO1);
    wire [`TDCHB_DW-1:0] head = sel_two ?
        head_data[2*`TDCHB_DW-1:`TDCHB_DW] : head_data[`TDCHB_DW-1:0];

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_fifo
            tdchb_buf #(.W(`TDCHB_DW)) u_buf (
                .ref_clk_i(ref_clk_i),
                .rst_n_i(rst_n_i),
                .clr_i(mrst),
                .in_valid_i(result_valid_i[gi]),
                .in_ready_o(result_ready_o[gi]),
                .in_data_i(result_data_i[gi*`TDCHB_DW +: `TDCHB_DW]),
                .out_valid_o(head_valid[gi]),
                .out_ready_i(pop[gi]),
                .out_data_o(head_data[gi*`TDCHB_DW +: `TDCHB_DW])
            );
        end
    endgenerate

    // pop at end of a wide read or of the first narrow access
    always @* begin
        pop = 2'b00;
        if (rd_end && sel_fifo && !(narrow_mode_o && rd_phase_q))
            pop[sel_two] = 1'b1;
    end

    // ****************************************
    // read path and drive control
    // ****************************************
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_o <= {`TDCHB_DW{1'b0}};
            data_oe_o <= 1'b0;
            rd_phase_q <= 1'b0;
            msw_q <= {`TDCHB_MSW_W{1'b0}};
            fifo_one_empty_indicator_o <= 1'b1;
            fifo_two_empty_indicator_o <= 1'b1;
        end else begin
            data_oe_o <= !hold_n || rd_act;
            fifo_one_empty_indicator_o <= !head_valid[0] || pop[0];
            fifo_two_empty_indicator_o <= !head_valid[1] || pop[1];
            if (rd_begin) begin
                if (!sel_fifo)
                    data_o <= {`TDCHB_DW{1'b0}};
                else if (!narrow_mode_o)
                    data_o <= head;
                else if (!rd_phase_q)
                    data_o <= {12'h000, head[`TDCHB_HW-1:0]};
                else
                    data_o <= {12'h000, 4'h0, msw_q};
            end
            if (rd_end && narrow_mode_o) begin
                rd_phase_q <= ~rd_phase_q;
                if (!rd_phase_q)
                    msw_q <= head[`TDCHB_DW-1:`TDCHB_HW];
            end
            if (mrst)
                rd_phase_q <= 1'b0;
        end
    end

    // ****************************************
    // write path and bus width
    // ****************************************
    reg wr_phase_q;
    reg [`TDCHB_HW-1:0] lsw_q;
    wire [`TDCHB_DW-1:0] wword = narrow_mode_o ?
        {wdata[`TDCHB_MSW_W-1:0], lsw_q} : wdata;
    wire wr_done = wr_end && (!narrow_mode_o || wr_phase_q);

    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_phase_q <= 1'b0;
            lsw_q <= {`TDCHB_HW{1'b0}};
            cfg_we_o <= 1'b0;
            cfg_addr_o <= {`TDCHB_AW{1'b0}};
            cfg_data_o <= {`TDCHB_DW{1'b0}};
            narrow_mode_o <= `TDCHB_NARROW_RST;
        end else begin
            cfg_we_o <= wr_done;
            if (wr_end && narrow_mode_o) begin
                wr_phase_q <= ~wr_phase_q;
                if (!wr_phase_q)
                    lsw_q <= wdata[`TDCHB_HW-1:0];
            end
            if (wr_done) begin
                cfg_addr_o <= addr;
                cfg_data_o <= wword;
                if (addr == `TDCHB_ADDR_BUSW)
                    narrow_mode_o <= wword[`TDCHB_BUSW_BIT];
            end
            if (mrst)
                wr_phase_q <= 1'b0;
        end
    end

    // ****************************************
    // hit rejection after resets
    // ****************************************
    reg [`TDCHB_CW-1:0] blk_q;
    reg [`TDCHB_CW-1:0] blk_d;

    // reload the window on each reset edge, never shortening it
    always @* begin
        blk_d = (blk_q != {`TDCHB_CW{1'b0}}) ?
            blk_q - 1'b1 : blk_q;
        if (mrst_rise && blk_d < MRISE_CYC)
            blk_d = MRISE_CYC;
        if (mrst_fall && blk_d < MFALL_CYC)
            blk_d = MFALL_CYC;
        if (prst_rise && blk_d < PRISE_CYC)
            blk_d = PRISE_CYC;
        if (prst_fall && blk_d < PFALL_CYC)
            blk_d = PFALL_CYC;
    end

    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            blk_q <= {`TDCHB_CW{1'b0}};
            hit_accept_o <= 1'b0;
            start_hit_o <= 1'b0;
            stop_hit_o <= {`TDCHB_NSTOP{1'b0}};
        end else begin
            blk_q <= blk_d;
            hit_accept_o <= !mrst && !prst &&
                (blk_d == {`TDCHB_CW{1'b0}});
            start_hit_o <= start_s && hit_accept_o;
            stop_hit_o <= stop_s & {`TDCHB_NSTOP{hit_accept_o}};
        end
    end
endmodule // tdchb_port
`default_nettype wire

/* File: hdl/tdchb_defines.vh */
// constants of the tdc host bus port
`ifndef TDCHB_DEFINES_VH
`define TDCHB_DEFINES_VH
`define TDCHB_DW 28
`define TDCHB_HW 16
`define TDCHB_MSW_W 12
`define TDCHB_AW 4
`define TDCHB_NSTOP 8
`define TDCHB_ADDR_FIFO1 4'h8
`define TDCHB_ADDR_FIFO2 4'h9
`define TDCHB_ADDR_BUSW 4'he
`define TDCHB_BUSW_BIT 4
`define TDCHB_NARROW_RST 1'b0
`define TDCHB_PIN_IDLE 6'h0f
`define TDCHB_CLK_PS 5000
`define TDCHB_MRST_RISE_NS 27
`define TDCHB_MRST_FALL_NS 13
`define TDCHB_PRST_RISE_NS 60
`define TDCHB_PRST_FALL_NS 13
`define TDCHB_CW 5
`endif

/* File: hdl/tdchb_buf.v */
// two-entry valid/ready buffer for one interface fifo
`default_nettype none
module tdchb_buf #(
    parameter W = 28
) (
    // clock and reset
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire clr_i,
    // filling side
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [W-1:0] in_data_i,
    // draining side
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [W-1:0] out_data_o
);
    reg [W-1:0] mem_q [0:1];
    reg wp_q;
    reg rp_q;
    reg [1:0] cnt_q;
    reg rdy_q;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;
    wire [1:0] cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};

    // ready comes from a flop, set from the next fill count
    assign in_ready_o = rdy_q;
    assign out_valid_o = (cnt_q != 2'h0);
    assign out_data_o = mem_q[rp_q];

    // pointers and fill count
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'h0;
            rdy_q <= 1'b1;
        end else if (clr_i) begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'h0;
            rdy_q <= 1'b1;
        end else begin
            if (push)
                wp_q <= ~wp_q;
            if (pop)
                rp_q <= ~rp_q;
            cnt_q <= cnt_d;
            rdy_q <= (cnt_d != 2'h2);
        end
    end

    // storage, no reset needed
    always @(posedge ref_clk_i) begin
        if (push)
            mem_q[wp_q] <= in_data_i;
    end
endmodule // tdchb_buf
`default_nettype wire

/* File: testbench/tdchb_monitor.sv */
// assertion checker for the tdc host bus port
`default_nettype none
module tdchb_monitor (
    // clock and reset
    input wire ref_clk_i,
    input wire rst_n_i,
    // watched pins and outputs
    input wire read_strobe_n_i,
    input wire output_drive_hold_n_i,
    input wire master_reset_i,
    input wire partial_reset_i,
    input wire data_oe_o,
    input wire hit_accept_o,
    input wire start_hit_o,
    input wire [7:0] stop_hit_o,
    input wire cfg_we_o,
    input wire [3:0] cfg_addr_o,
    input wire [27:0] cfg_data_o,
    input wire narrow_mode_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    a_hold_drive: assert property (
        (!output_drive_hold_n_i)[*5] |-> data_oe_o) else $error("no drive");
    a_idle_float: assert property (
        (output_drive_hold_n_i && read_strobe_n_i)[*5] |-> !data_oe_o)
        else $error("stray drive");
    a_read_drive: assert property (
        $fell(read_strobe_n_i) |-> ##[2:4] data_oe_o) else $error("read late");
    a_width_set: assert property (
        cfg_we_o && cfg_addr_o == 4'he |-> ##2 narrow_mode_o == cfg_data_o[4])
        else $error("bus width");
    a_mrst_rise: assert property (
        $rose(master_reset_i) |-> ##4 (!hit_accept_o)[*5]) else $error("mr");
    a_mrst_fall: assert property (
        $fell(master_reset_i) |-> ##3 (!hit_accept_o)[*2]) else $error("mf");
    a_prst_rise: assert property (
        $rose(partial_reset_i) |-> ##4 (!hit_accept_o)[*8]) else $error("pr");
    a_hit_gate: assert property (
        (!hit_accept_o)[*4] |-> !start_hit_o && stop_hit_o == 8'h00)
        else $error("hit leak");
endmodule // tdchb_monitor
bind tdchb_port tdchb_monitor u_tdchb_monitor (.ref_clk_i, .rst_n_i,
    .read_strobe_n_i, .output_drive_hold_n_i, .master_reset_i,
    .partial_reset_i, .data_oe_o, .hit_accept_o, .start_hit_o, .stop_hit_o,
    .cfg_we_o, .cfg_addr_o, .cfg_data_o, .narrow_mode_o);
`default_nettype wire

/* File: testbench/tdchb_host.sv */
// host processor model for the asynchronous bus port
`default_nettype none
module tdchb_host (
    // clock and device outputs
    input wire ref_clk_i,
    input wire [27:0] data_o,
    input wire [1:0] empty_i,
    // bus pins and read results
    output logic cs_n_o = 1'b1,
    output logic rd_n_o = 1'b1,
    output logic wr_n_o = 1'b1,
    output logic hold_n_o = 1'b1,
    output logic [3:0] addr_o = 4'h0,
    output logic [27:0] wdata_o = 28'h0,
    output logic wdrive_o = 1'b0,
    output logic rd_done_o = 1'b0,
    output logic [27:0] rd_val_o = 28'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [27:0] lo, hi;
    // one access; data held three cycles past the strobe
    task automatic acc(input logic w, input logic [3:0] a,
                       input logic [27:0] d, output logic [27:0] q);
        @(negedge ref_clk_i);
        if (w) hold_n_o = 1'b1;
        {cs_n_o, addr_o, wdata_o, wdrive_o} = {1'b0, a, d, w};
        {rd_n_o, wr_n_o} = {w, !w};
        repeat (5) @(posedge ref_clk_i);
        q = data_o;
        @(negedge ref_clk_i);
        {rd_n_o, wr_n_o} = 2'b11;
        repeat (3) @(negedge ref_clk_i);
        {cs_n_o, wdrive_o} = 2'b10;
        repeat (3) @(negedge ref_clk_i);
    endtask
    task automatic set_hold(input logic v);
        @(negedge ref_clk_i);
        hold_n_o = v;
    endtask
    // one result, two accesses when narrow
    task automatic read(input logic [3:0] a, input logic n, output logic e);
        e = 1'bx;
        if (empty_i[a[0]] !== 1'b0) return;
        acc(1'b0, a, 28'h0, lo);
        e = empty_i[a[0]];
        if (n) acc(1'b0, a, 28'h0, hi);
        rd_val_o = n ? {hi[11:0], lo[15:0]} : lo;
        rd_done_o = 1'b1;
        @(negedge ref_clk_i);
        rd_done_o = 1'b0;
    endtask
    task automatic write(input logic [3:0] a, input logic [27:0] d,
                         input logic n, input logic [3:0] j);
        if (!n) acc(1'b1, a, d, lo);
        else begin
            acc(1'b1, a, {12'h0, d[15:0]}, lo);
            acc(1'b1, a, {12'h0, j, d[27:16]}, lo);
        end
    endtask
endmodule // tdchb_host
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the tdc host bus port
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [1:0] rst2 = 2'b0;
    logic [8:0] hits = 9'h0;
    logic [1:0] rvalid = 2'b0;
    logic [55:0] rdata = 56'h0;
    logic [31:0] exp_q[$];
    logic [27:0] w0, w1, w2;
    logic [27:0] dq;
    logic hit_q = 1'b0;
    logic ef;
    int fail_count = 0;
    int check_count = 0;
    wire cs_n, rd_n, wr_n, hold_n, wdrive, rd_done, oe, we, narrow, st, acpt;
    wire [1:0] rready, empty;
    wire [3:0] addr, caddr;
    wire [7:0] sp;
    wire [27:0] wdata, dout, din, rd_val, cdata;
    // bus wire, pulled down when idle
    assign din = wdrive ? wdata : (oe ? dout : 28'h0);
    always #2.5 ref_clk_i = ~ref_clk_i;
    tdchb_port u_tdchb_port (.ref_clk_i, .rst_n_i, .chip_select_n_i(cs_n),
        .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n), .addr_i(addr),
        .output_drive_hold_n_i(hold_n), .data_i(din), .data_o(dout),
        .data_oe_o(oe), .fifo_one_empty_indicator_o(empty[0]),
        .fifo_two_empty_indicator_o(empty[1]), .master_reset_i(rst2[0]),
        .partial_reset_i(rst2[1]), .start_hit_i(hits[8]),
        .stop_hit_i(hits[7:0]), .start_hit_o(st), .stop_hit_o(sp),
        .hit_accept_o(acpt), .result_valid_i(rvalid),
        .result_ready_o(rready), .result_data_i(rdata), .cfg_we_o(we),
        .cfg_addr_o(caddr), .cfg_data_o(cdata), .narrow_mode_o(narrow));
    tdchb_host u_tdchb_host (.ref_clk_i, .data_o(dout), .empty_i(empty),
        .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .hold_n_o(hold_n),
        .addr_o(addr), .wdata_o(wdata), .wdrive_o(wdrive),
        .rd_done_o(rd_done), .rd_val_o(rd_val));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] nxt();
        return exp_q.size() > 0 ? exp_q.pop_front() : 32'hx;
    endfunction
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // a bounded wait that ran out ends the run
    task automatic give_up(input int n);
        if (n < 50) return;
        fail_count++;
        print_verdict;
    endtask
    task automatic push(input int f, input logic [27:0] w);
        int n;
        @(negedge ref_clk_i);
        rvalid[f] = 1'b1;
        rdata[f*28+:28] = w;
        for (n = 0; n < 50 && rready[f] !== 1'b1; n++) @(negedge ref_clk_i);
        give_up(n);
        @(negedge ref_clk_i);
        rvalid[f] = 1'b0;
    endtask
    task automatic hit(input logic [8:0] s);
        @(negedge ref_clk_i);
        hits = s;
        repeat (2) @(negedge ref_clk_i);
        hits = 9'h0;
    endtask
    // watcher: each result takes the oldest note
    always @(posedge ref_clk_i) begin
        hit_q <= st;
        if (we === 1'b1) chk({caddr, cdata}, nxt());
        if (rd_done === 1'b1) chk(rd_val, nxt());
        if ({st, hit_q} === 2'b10) chk({st, sp}, nxt());
    end
    initial begin
        int n;
        w0 = $urandom(83);
        repeat (6) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        {w0, w1, w2} = {$urandom, $urandom, $urandom};
        push(0, w0);
        push(0, w1);
        push(1, w2);
        repeat (3) @(negedge ref_clk_i);
        chk({rready[0], empty}, 3'h0);
        exp_q = '{{4'h0, w0}, {4'h0, w1}, {4'h0, w2}};
        u_tdchb_host.read(4'h8, 1'b0, ef);
        // extra dummy strobe between reads pops nothing
        u_tdchb_host.acc(1'b0, 4'h0, 28'h0, dq);
        chk(dq, 28'h0);
        chk(empty[0], 1'b0);
        u_tdchb_host.read(4'h8, 1'b0, ef);
        u_tdchb_host.read(4'h9, 1'b0, ef);
        chk(empty, 2'b11);
        u_tdchb_host.set_hold(1'b0);
        repeat (6) @(negedge ref_clk_i);
        chk({oe, dout}, {1'b1, w2});
        u_tdchb_host.set_hold(1'b1);
        repeat (6) @(negedge ref_clk_i);
        chk(oe, 1'b0);
        $display("wide readout and drive hold done");
        exp_q = '{{4'he, 28'h0000010}, {4'h0, w1}, {4'h3, w0}, 32'he0000000};
        u_tdchb_host.write(4'he, 28'h0000010, 1'b0, 4'h0);
        chk(narrow, 1'b1);
        push(0, w1);
        repeat (3) @(negedge ref_clk_i);
        u_tdchb_host.read(4'h8, 1'b1, ef);
        chk({ef, dout[15:12]}, 5'h10);
        u_tdchb_host.write(4'h3, w0, 1'b1, w2[3:0]);
        u_tdchb_host.write(4'he, 28'h0, 1'b1, 4'hf);
        chk(narrow, 1'b0);
        $display("narrow mode done");
        for (int p = 1; p < 3; p++) begin
            @(negedge ref_clk_i);
            rst2 = p[1:0];
            hit(9'h13c); // lost while the reset pin is high
            rst2 = 2'b0;
            for (n = 0; n < 50 && acpt !== 1'b1; n++) @(negedge ref_clk_i);
            give_up(n);
            exp_q.push_back({1'b1, w1[7:0]});
            hit({1'b1, w1[7:0]});
            w1 = $urandom;
        end
        for (n = 0; n < 50 && exp_q.size() > 0; n++) @(negedge ref_clk_i);
        give_up(n);
        $display("hit gating done");
        print_verdict;
    end
endmodule // testbench
`default_nettype wire
